// ---- design/mrw_handler.sv ----
// slave handler for the combined write-then-read holding register query
// Functional notes
// - all writes done before any read
// - read part limited to 125 registers
// - write part limited to 121 registers
// - reads issued in ascending address order
// - writes committed ascending from write start
// - rejected values do not stop other writes
// - query fields parsed in fixed order
// - byte count must equal twice write count
// - response echoes address, function, read byte count
// - register values sent upper byte first
// - frame check low byte first, over preceding bytes
`timescale 1ns/1ps
module mrw_handler (
    input wire logic mclk_i,                  // 40 MHz clock
    input wire logic sys_rst_i,               // async reset, high
    input wire logic [7:0] my_addr_i,         // own slave address
    input wire logic rx_start_i,              // pulse: new query begins
    input wire logic [7:0] rx_data_i,         // query byte
    input wire logic rx_valid_i,              // query byte valid
    output logic rx_ready_o,                  // handler takes bytes
    output logic reg_req_o,                   // register access request
    output logic reg_we_o,                    // 1 write, 0 read
    output logic [15:0] reg_addr_o,           // register address
    output logic [15:0] reg_wdata_o,          // value to write
    input wire logic [15:0] reg_rdata_i,      // value read
    input wire logic reg_ack_i,               // access done pulse
    input wire logic reg_err_i,               // write value rejected
    output logic [7:0] tx_data_o,             // response byte
    output logic tx_valid_o,                  // response byte valid
    input wire logic tx_ready_i,              // response byte taken
    output logic busy_o                       // query in progress
);
    import mrw_pkg::*;

    mrw_state_t state, next_state;
    logic [8:0] idx, next_idx;
    logic [7:0] slave, next_slave, func, next_func, bcnt, next_bcnt, hi, next_hi;
    logic [15:0] rd_start, next_rd_start, rd_cnt, next_rd_cnt;
    logic [15:0] wr_start, next_wr_start, wr_cnt, next_wr_cnt;
    logic [15:0] crc, next_crc, tcrc, next_tcrc, rbuf, next_rbuf;
    logic [15:0] next_addr, next_wdata;
    logic [6:0] wi, next_wi, ri, next_ri;
    logic [1:0] sub, next_sub;
    logic bad, next_bad, exc, next_exc, next_req, next_we;
    logic [15:0] wbuf [128];
    logic wb_we;
    logic [6:0] wb_idx;
    logic [15:0] wb_d;
    logic push_v, push_rdy, fire;
    logic [7:0] push_d;
    logic [8:0] data_off;

    // one byte step of the reflected check
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // parser, access sequencer and response builder next values
    always_comb begin
        next_state = state;
        next_idx = idx;
        next_slave = slave;
        next_func = func;
        next_bcnt = bcnt;
        next_hi = hi;
        next_rd_start = rd_start;
        next_rd_cnt = rd_cnt;
        next_wr_start = wr_start;
        next_wr_cnt = wr_cnt;
        next_crc = crc;
        next_tcrc = tcrc;
        next_rbuf = rbuf;
        next_addr = reg_addr_o;
        next_wdata = reg_wdata_o;
        next_req = reg_req_o;
        next_we = reg_we_o;
        next_wi = wi;
        next_ri = ri;
        next_sub = sub;
        next_bad = bad;
        next_exc = exc;
        wb_we = 1'b0;
        data_off = idx - IX_DATA;
        wb_idx = data_off[7:1];
        wb_d = {hi, rx_data_i};
        // only response states offer bytes; fire is settled before the case reads it
        push_v = (state != MRW_RX) && (state != MRW_WR) && (state != MRW_RD);
        fire = push_v && push_rdy;
        push_d = 8'h00;
        unique case (state)
            MRW_RX: begin
                if (rx_start_i) begin
                    next_idx = IX_SLAVE;
                    next_crc = CRC_INIT;
                end else if (rx_valid_i) begin
                    next_crc = crc_byte(crc, rx_data_i);
                    next_idx = (idx == IX_MAX) ? idx : 9'(idx + 1'b1);
                    // fields taken in their fixed order
                    unique case (idx)
                        IX_SLAVE: next_slave = rx_data_i;
                        IX_FUNC: next_func = rx_data_i;
                        IX_RS_HI: next_rd_start[15:8] = rx_data_i;
                        IX_RS_LO: next_rd_start[7:0] = rx_data_i;
                        IX_RC_HI: next_rd_cnt[15:8] = rx_data_i;
                        IX_RC_LO: next_rd_cnt[7:0] = rx_data_i;
                        IX_WS_HI: next_wr_start[15:8] = rx_data_i;
                        IX_WS_LO: next_wr_start[7:0] = rx_data_i;
                        IX_WC_HI: next_wr_cnt[15:8] = rx_data_i;
                        IX_WC_LO: next_wr_cnt[7:0] = rx_data_i;
                        IX_BCNT: begin
                            next_bcnt = rx_data_i;
                            next_bad = (rd_cnt == 16'h0000) || (rd_cnt > MAX_RD)
                                || (wr_cnt == 16'h0000) || (wr_cnt > MAX_WR)
                                || ({8'h00, rx_data_i} != {wr_cnt[14:0], 1'b0});
                        end
                        default: begin
                            // write values stored only when the counts and byte count are valid
                            if (idx < 9'({1'b0, bcnt} + IX_DATA)) begin
                                next_hi = rx_data_i;
                                wb_we = data_off[0] && !bad;
                            end
                            if (idx == 9'({1'b0, bcnt} + IX_TAIL)) begin
                                next_idx = IX_MAX;
                                if (next_crc == 16'h0000 && slave == my_addr_i
                                    && func == FUNC_RW) begin
                                    next_tcrc = CRC_INIT;
                                    next_sub = 2'd0;
                                    next_wi = 7'd0;
                                    next_exc = bad;
                                    next_state = bad ? MRW_HDR : MRW_WR;
                                end
                            end
                        end
                    endcase
                end
            end
            MRW_WR: begin
                // writes one by one, ascending, before any read
                if (!reg_req_o) begin
                    next_req = 1'b1;
                    next_we = 1'b1;
                    next_addr = wr_start + {9'h000, wi};
                    next_wdata = wbuf[wi];
                end else if (reg_ack_i) begin
                    next_req = 1'b0;
                    next_exc = exc || reg_err_i;
                    if ({9'h000, wi} == wr_cnt - 16'h0001) begin
                        next_state = MRW_HDR;
                    end else begin
                        next_wi = 7'(wi + 1'b1);
                    end
                end
            end
            MRW_HDR: begin
                // echo address and function, then byte count or code
                push_v = 1'b1;
                unique case (sub)
                    2'd0: push_d = slave;
                    2'd1: push_d = exc ? (func | EXC_FLAG) : func;
                    default: push_d = exc ? EXC_DATA_VALUE : {rd_cnt[6:0], 1'b0};
                endcase
                if (fire) begin
                    next_sub = 2'(sub + 1'b1);
                    next_ri = 7'd0;
                    if (sub == 2'd2) begin
                        next_state = exc ? MRW_CRCL : MRW_RD;
                    end
                end
            end
            MRW_RD: begin
                // reads fetched ascending from read start
                if (!reg_req_o) begin
                    next_req = 1'b1;
                    next_we = 1'b0;
                    next_addr = rd_start + {9'h000, ri};
                end else if (reg_ack_i) begin
                    next_req = 1'b0;
                    next_rbuf = reg_rdata_i;
                    next_state = MRW_RDH;
                end
            end
            MRW_RDH: begin
                push_v = 1'b1;
                push_d = rbuf[15:8];
                if (fire) begin
                    next_state = MRW_RDL;
                end
            end
            MRW_RDL: begin
                push_v = 1'b1;
                push_d = rbuf[7:0];
                if (fire) begin
                    next_ri = 7'(ri + 1'b1);
                    next_state = ({9'h000, ri} == rd_cnt - 16'h0001) ? MRW_CRCL : MRW_RD;
                end
            end
            MRW_CRCL: begin
                push_v = 1'b1;
                push_d = tcrc[7:0];
                if (fire) begin
                    next_state = MRW_CRCH;
                end
            end
            MRW_CRCH: begin
                push_v = 1'b1;
                push_d = tcrc[15:8];
                if (fire) begin
                    next_state = MRW_RX;
                    next_idx = IX_SLAVE;
                    next_crc = CRC_INIT;
                end
            end
        endcase
        if (fire && state != MRW_CRCL && state != MRW_CRCH) begin
            next_tcrc = crc_byte(tcrc, push_d);
        end
    end

    // handler state registers
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= MRW_RX;
            idx <= IX_SLAVE;
            slave <= 8'h00;
            func <= 8'h00;
            bcnt <= 8'h00;
            hi <= 8'h00;
            rd_start <= 16'h0000;
            rd_cnt <= 16'h0000;
            wr_start <= 16'h0000;
            wr_cnt <= 16'h0000;
            crc <= CRC_INIT;
            tcrc <= CRC_INIT;
            rbuf <= 16'h0000;
            reg_addr_o <= 16'h0000;
            reg_wdata_o <= 16'h0000;
            reg_req_o <= 1'b0;
            reg_we_o <= 1'b0;
            wi <= 7'd0;
            ri <= 7'd0;
            sub <= 2'd0;
            bad <= 1'b0;
            exc <= 1'b0;
            rx_ready_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            slave <= next_slave;
            func <= next_func;
            bcnt <= next_bcnt;
            hi <= next_hi;
            rd_start <= next_rd_start;
            rd_cnt <= next_rd_cnt;
            wr_start <= next_wr_start;
            wr_cnt <= next_wr_cnt;
            crc <= next_crc;
            tcrc <= next_tcrc;
            rbuf <= next_rbuf;
            reg_addr_o <= next_addr;
            reg_wdata_o <= next_wdata;
            reg_req_o <= next_req;
            reg_we_o <= next_we;
            wi <= next_wi;
            ri <= next_ri;
            sub <= next_sub;
            bad <= next_bad;
            exc <= next_exc;
            rx_ready_o <= (next_state == MRW_RX);
            busy_o <= (next_state != MRW_RX);
        end
    end

    // write value store
    always_ff @(posedge mclk_i) begin
        if (wb_we) begin
            wbuf[wb_idx] <= wb_d;
        end
    end

    // response bytes wait here until the link takes them
    mrw_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(mclk_i),
        .rst_i(sys_rst_i),
        .in_data_i(push_d),
        .in_valid_i(push_v),
        .in_ready_o(push_rdy),
        .out_data_o(tx_data_o),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    rd_after_wr_a: assert property ((reg_req_o && !reg_we_o) |->
        ({9'h000, wi} == wr_cnt - 16'h0001)) else $error("read before writes done");
    rd_limit_a: assert property ((reg_req_o && !reg_we_o) |->
        (rd_cnt <= MAX_RD && {9'h000, ri} < rd_cnt)) else $error("read beyond limit");
    wr_limit_a: assert property ((reg_req_o && reg_we_o) |->
        (wr_cnt <= MAX_WR && {9'h000, wi} < wr_cnt)) else $error("write beyond limit");
    rd_ascend_a: assert property ((reg_req_o && !reg_we_o) |->
        (reg_addr_o == rd_start + {9'h000, ri})) else $error("read address out of order");
    wr_ascend_a: assert property ((reg_req_o && reg_we_o) |->
        (reg_addr_o == wr_start + {9'h000, wi} && reg_wdata_o == wbuf[wi]))
        else $error("write address or value wrong");
    wr_continue_a: assert property ((reg_req_o && reg_we_o && reg_ack_i && reg_err_i
        && {9'h000, wi} != wr_cnt - 16'h0001) |=> !reg_req_o ##1 (reg_req_o && reg_we_o))
        else $error("writes stopped after rejection");
    bcnt_check_a: assert property ((state == MRW_RX && next_state == MRW_WR) |->
        ({8'h00, bcnt} == {wr_cnt[14:0], 1'b0})) else $error("byte count not checked");
    hdr_echo_a: assert property ((state == MRW_HDR && fire) |->
        (sub != 2'd0 || push_d == slave) && (sub != 2'd2 || exc
        || push_d == {rd_cnt[6:0], 1'b0})) else $error("response header wrong");
    byte_order_a: assert property ((state == MRW_RDH && fire) |=>
        (state == MRW_RDL && push_d == rbuf[7:0] && $past(push_d) == rbuf[15:8]))
        else $error("value byte order wrong");
    crc_order_a: assert property ((state == MRW_CRCL && fire) |-> (push_d == tcrc[7:0])
        ##1 (state == MRW_CRCH && push_d == tcrc[15:8])) else $error("check bytes wrong");
    bad_no_access_a: assert property (bad |-> !reg_req_o)
        else $error("access on rejected query");

    cov_normal_c: cover property (state == MRW_RDL && fire && !exc);
    cov_exc_c: cover property (state == MRW_HDR && sub == 2'd2 && fire && bad);
    cov_reject_c: cover property (reg_req_o && reg_we_o && reg_ack_i && reg_err_i);
    cov_stall_c: cover property (push_v && !push_rdy);
endmodule

// ---- include/mrw_pkg.sv ----
// constants and types for the combined read/write register handler
package mrw_pkg;
    localparam logic [7:0] FUNC_RW = 8'h17;          // combined read/write function code
    localparam logic [7:0] EXC_FLAG = 8'h80;         // set in function code of an exception
    localparam logic [7:0] EXC_DATA_VALUE = 8'h03;   // exception code for bad data
    localparam logic [15:0] MAX_RD = 16'h007D;       // 125 registers read at most
    localparam logic [15:0] MAX_WR = 16'h0079;       // 121 registers written at most
    localparam logic [15:0] CRC_INIT = 16'hFFFF;     // check register start value
    localparam logic [15:0] CRC_POLY = 16'hA001;     // reflected check polynomial
    localparam logic [8:0] IX_SLAVE = 9'h000;        // query byte positions
    localparam logic [8:0] IX_FUNC = 9'h001;
    localparam logic [8:0] IX_RS_HI = 9'h002;
    localparam logic [8:0] IX_RS_LO = 9'h003;
    localparam logic [8:0] IX_RC_HI = 9'h004;
    localparam logic [8:0] IX_RC_LO = 9'h005;
    localparam logic [8:0] IX_WS_HI = 9'h006;
    localparam logic [8:0] IX_WS_LO = 9'h007;
    localparam logic [8:0] IX_WC_HI = 9'h008;
    localparam logic [8:0] IX_WC_LO = 9'h009;
    localparam logic [8:0] IX_BCNT = 9'h00A;
    localparam logic [8:0] IX_DATA = 9'h00B;         // first write value byte
    localparam logic [8:0] IX_TAIL = 9'h00C;         // data start plus one check byte
    localparam logic [8:0] IX_MAX = 9'h1FF;          // byte index saturates here
    localparam int FIFO_DEPTH = 32;
    localparam int BYTE_W = 8;

    typedef enum logic [2:0] {
        MRW_RX, MRW_WR, MRW_HDR, MRW_RD, MRW_RDH, MRW_RDL, MRW_CRCL, MRW_CRCH
    } mrw_state_t;
endpackage

// ---- design/mrw_fifo.sv ----
// response byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module mrw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,               // clock
    input wire logic rst_i,               // async reset, high
    input wire logic [WIDTH-1:0] in_data_i, // data to store
    input wire logic in_valid_i,          // store request
    output logic in_ready_o,              // room available
    output logic [WIDTH-1:0] out_data_o,  // head data
    output logic out_valid_o,             // head valid
    input wire logic out_ready_i          // head taken
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // pointer and fill level next values
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    // pointer, level and flag registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_o <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_o <= (next_count != (AW+1)'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end

    // storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign out_data_o = mem[rd_ptr];
endmodule

// ---- sim/mrw_master_model.sv ----
// bus master model: sends query frames and collects the response bytes
`timescale 1ns/1ps
module mrw_master_model (
    input wire logic mclk_i,       // clock
    output logic rx_start_o,       // frame start pulse
    output logic [7:0] rx_data_o,  // query byte
    output logic rx_valid_o,       // query byte valid
    input wire logic rx_ready_i,   // handler takes bytes
    input wire logic [7:0] tx_data_i, // response byte
    input wire logic tx_valid_i,   // response byte valid
    output logic tx_ready_o        // response byte taken
);
    logic slow;
    logic [1:0] ph;
    logic [7:0] resp [$];
    initial begin
        rx_start_o = 1'b0;
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
        slow = 1'b0;
        ph = 2'h0;
    end
    // collect response; when slow, take a byte only one cycle in three
    always @(posedge mclk_i) begin
        if (tx_valid_i && tx_ready_o) resp.push_back(tx_data_i);
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        tx_ready_o <= !slow || (ph == 2'h1);
    end
    // whole frames only: start pulse, then each query byte held until the handler takes it
    task send(input logic [7:0] q[$]);
        @(posedge mclk_i);
        rx_start_o <= 1'b1;
        @(posedge mclk_i);
        rx_start_o <= 1'b0;
        foreach (q[i]) begin
            rx_data_o <= q[i];
            rx_valid_o <= 1'b1;
            do @(posedge mclk_i); while (rx_ready_i !== 1'b1);
        end
        rx_valid_o <= 1'b0;
        rx_data_o <= ~q[q.size() - 1];
    endtask
endmodule

// ---- sim/mrw_handler_tb_top.sv ----
// self-checking bench for the combined write-then-read handler
`timescale 1ns/1ps
module mrw_handler_tb_top;
    import mrw_pkg::*;
    localparam logic [7:0] SLV = 8'h01;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic rx_start, rx_valid, rx_ready, reg_req, reg_we, tx_valid, tx_ready, busy;
    logic reg_ack = 1'b0;
    logic reg_err = 1'b0;
    logic [7:0] rx_data, tx_data;
    logic [15:0] reg_addr, reg_wdata;
    logic [15:0] reg_rdata = 16'h0000;
    logic [15:0] bad_addr = 16'hFFFF;
    logic [15:0] mem [0:65535];
    logic [15:0] shadow [0:65535];
    logic [32:0] acc_log [$];
    logic [7:0] fq [$];
    logic [7:0] eq [$];
    logic busy_hi = 1'b0;
    int dly = 0;
    int wait_n = 0;
    int bad_count = 0;
    int checked = 0;

    always #12.5 mclk_i = ~mclk_i;

    mrw_handler dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .my_addr_i(SLV),
        .rx_start_i(rx_start), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
        .reg_req_o(reg_req), .reg_we_o(reg_we), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata), .reg_ack_i(reg_ack), .reg_err_i(reg_err), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .busy_o(busy));
    mrw_master_model master_u (.mclk_i(mclk_i), .rx_start_o(rx_start), .rx_data_o(rx_data),
        .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready));

    // register space: acks after dly cycles, logs every access, refuses bad_addr writes
    always @(posedge mclk_i) begin
        if (reg_ack) begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            reg_rdata <= ~reg_rdata;
        end else if (reg_req && wait_n < dly) begin
            wait_n <= wait_n + 1;
        end else if (reg_req) begin
            wait_n <= 0;
            reg_ack <= 1'b1;
            reg_err <= reg_we && reg_addr == bad_addr;
            reg_rdata <= mem[reg_addr];
            acc_log.push_back({reg_we, reg_addr, reg_we ? reg_wdata : mem[reg_addr]});
            if (reg_we && reg_addr != bad_addr) mem[reg_addr] <= reg_wdata;
        end
    end

    task chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [15:0] wval(input logic [15:0] a);
        return a ^ 16'h5A3C;
    endfunction

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction

    // append check, low byte first
    task automatic add_crc(ref logic [7:0] q[$]);
        logic [15:0] c;
        c = crc16(q);
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask

    // query fields in fixed order, write values upper byte first
    task build(input logic [7:0] sa, input logic [15:0] rs, rc, ws, wc, bc);
        logic [15:0] v;
        fq = {sa, FUNC_RW, rs[15:8], rs[7:0], rc[15:8], rc[7:0], ws[15:8], ws[7:0]};
        fq = {fq, wc[15:8], wc[7:0], bc[7:0]};
        for (int i = 0; i < bc / 2; i++) begin
            v = wval(ws + 16'(i));
            fq.push_back(v[15:8]);
            fq.push_back(v[7:0]);
        end
        add_crc(fq);
    endtask

    // send one frame, then wait until the answer has drained
    task run();
        acc_log.delete();
        master_u.resp.delete();
        master_u.send(fq);
        repeat (3) @(posedge mclk_i);
        busy_hi = busy;
        for (int n = 0; n < 20000 && !(rx_ready === 1'b1 && tx_valid === 1'b0); n++)
            @(posedge mclk_i);
        chk("drained", 1, rx_ready === 1'b1 && tx_valid === 1'b0 && busy === 1'b0);
    endtask

    task cmp_resp();
        chk("busy while answering", 1, busy_hi);
        chk("resp length", eq.size(), master_u.resp.size());
        foreach (eq[i]) chk("resp byte", eq[i], master_u.resp[i]);
    endtask

    // normal answer plus the access sequence behind it
    task chk_norm(input logic [15:0] rs, rc, ws, wc);
        logic [15:0] v;
        for (int i = 0; i < wc; i++) shadow[ws + 16'(i)] = wval(ws + 16'(i));
        chk("access count", wc + rc, acc_log.size());
        for (int i = 0; i < wc; i++)
            chk("write access", {1'b1, ws + 16'(i), wval(ws + 16'(i))}, acc_log[i]);
        eq = {SLV, FUNC_RW, 8'(rc << 1)};
        for (int i = 0; i < rc; i++) begin
            v = shadow[rs + 16'(i)];
            chk("read access", {1'b0, rs + 16'(i), v}, acc_log[wc + i]);
            eq.push_back(v[15:8]);
            eq.push_back(v[7:0]);
        end
        add_crc(eq);
        cmp_resp();
    endtask

    task chk_exc();
        eq = {SLV, FUNC_RW | EXC_FLAG, EXC_DATA_VALUE};
        add_crc(eq);
        cmp_resp();
    endtask

    task t_example();
        logic [15:0] tv [4] = '{16'h0000, 16'h017F, 16'h0000, 16'h01AA};
        foreach (tv[i]) mem[16'h00F8 + 16'(i)] = tv[i];
        foreach (tv[i]) shadow[16'h00F8 + 16'(i)] = tv[i];
        dly = 1;
        build(SLV, 16'h00F8, 16'h0004, 16'h1842, 16'h0004, 16'h0008);
        run();
        chk_norm(16'h00F8, 16'h0004, 16'h1842, 16'h0004);
        chk("check low", 8'h40, master_u.resp[11]);
        chk("check high", 8'h63, master_u.resp[12]);
        $display("test example done");
    endtask

    task t_drop();
        build(8'h02, 16'h0010, 16'h0001, 16'h0020, 16'h0001, 16'h0002);
        run();
        chk("foreign resp", 0, master_u.resp.size() + acc_log.size() + busy_hi);
        build(SLV, 16'h0010, 16'h0001, 16'h0020, 16'h0001, 16'h0002);
        fq[fq.size() - 1] ^= 8'h01;
        run();
        chk("bad check resp", 0, master_u.resp.size() + acc_log.size() + busy_hi);
        // sound check but another function code: must be dropped too
        build(SLV, 16'h0010, 16'h0001, 16'h0020, 16'h0001, 16'h0002);
        fq[1] = 8'h10;
        void'(fq.pop_back());
        void'(fq.pop_back());
        add_crc(fq);
        run();
        chk("other function resp", 0, master_u.resp.size() + acc_log.size() + busy_hi);
        $display("test drop done");
    endtask

    task t_bad();
        logic [15:0] cs [4][3] = '{'{16'h007E, 16'h0001, 16'h0002},
            '{16'h0001, 16'h007A, 16'h00F4}, '{16'h0001, 16'h0002, 16'h0006},
            '{16'h0000, 16'h0001, 16'h0002}};
        foreach (cs[k]) begin
            build(SLV, 16'h4000, cs[k][0], 16'h4100, cs[k][1], cs[k][2]);
            run();
            chk_exc();
            chk("no access", 0, acc_log.size());
        end
        $display("test bad counts done");
    endtask

    task t_reject();
        logic [15:0] a;
        bad_addr = 16'h3002;
        build(SLV, 16'h3000, 16'h0002, 16'h3000, 16'h0004, 16'h0008);
        run();
        chk_exc();
        for (int i = 0; i < 4; i++) begin
            a = 16'h3000 + 16'(i);
            shadow[a] = (i == 2) ? ~a : wval(a);
            chk("write access", {1'b1, a, wval(a)}, acc_log[i]);
            chk("kept value", shadow[a], mem[a]);
        end
        bad_addr = 16'hFFFF;
        $display("test rejected write done");
    endtask

    // largest counts, overlapping ranges, stalled response side
    task t_limits();
        master_u.slow = 1'b1;
        dly = 0;
        build(SLV, 16'h1FF0, 16'h007D, 16'h2000, 16'h0079, 16'h00F2);
        run();
        chk_norm(16'h1FF0, 16'h007D, 16'h2000, 16'h0079);
        master_u.slow = 1'b0;
        $display("test limits done");
    endtask

    task results();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = ~16'(a);
            shadow[a] = ~16'(a);
        end
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        t_example();
        t_drop();
        t_bad();
        t_reject();
        t_limits();
        results();
    end

    // watchdog: all tests need well under 10000 cycles
    initial begin
        repeat (40000) @(posedge mclk_i);
        bad_count++;
        $display("watchdog expired");
        results();
    end
endmodule
